// *** hdl/lec_pkg.sv ***
// Overview of operation
// - enhancements act only while the PHY enhance gate input is high
// - upper sixteen bits always read as zero
// - overlap disable bit stops out-of-order async transmit pipelining, default zero
// - start level 00 2K, 01 1.7K default, 10 1K, 11 512 bytes
// - after an underrun the retry uses the 2K store-and-forward threshold
// - below 2K, start at threshold or when whole packet is in FIFO
// - FIFO empty before packet end is an underrun; retry waits for full packet
// - at 2K, sending waits for the end-of-packet token
// - cleared transmit retries register forces store-and-forward
// - MPEG stamp fix bit applies to streams with FMT 20h, default zero
// - DV stamp fix bit applies to streams with FMT 00h, default zero
// - priority request bit makes link answer with priority arbitration
// - acceleration bit tells the PHY the link supports acceleration
// - bits 11, 9, 6, 5 to 3, 2 and 0 read as zero
// - bits 15, 10, 8, 7, 1 cleared only by global reset
// - bits load from software writes or from serial EEPROM
package lec_pkg;
   localparam int ADDR_W = 12;
   localparam logic [11:0] LINK_ENH_OFFSET = 12'h0f4;
   localparam logic [11:0] STATUS_OFFSET = 12'h0f0;
   localparam logic [31:0] LINK_ENH_RESET = 32'h00001000;
   // writable bits: 15, 13, 12, 10, 8, 7, 1
   localparam logic [15:0] LINK_ENH_WMASK = 16'hb582;
   // the subset kept only by the global reset
   localparam logic [15:0] GLOBAL_MASK = 16'h8582;
   localparam int BIT_OVERLAP_DIS = 15;
   localparam int BIT_LEVEL_LO = 12;
   localparam int BIT_MPEG_FIX = 10;
   localparam int BIT_DV_FIX = 8;
   localparam int BIT_PRIO_REQ = 7;
   localparam int BIT_ACCEL = 1;
   localparam int ST_RETRY = 0;
   localparam int ST_SFWD = 1;
   localparam int ST_LEVEL_LO = 2;
   localparam int ST_GATE = 4;
   localparam int BYTES_W = 12;
   localparam logic [1:0] LEVEL_2K = 2'h0;
   localparam logic [1:0] LEVEL_1K7 = 2'h1;
   localparam logic [1:0] LEVEL_1K = 2'h2;
   localparam logic [1:0] LEVEL_512 = 2'h3;
   localparam logic [11:0] BYTES_2K = 12'h800;
   localparam logic [11:0] BYTES_1K7 = 12'h6cd;
   localparam logic [11:0] BYTES_1K = 12'h400;
   localparam logic [11:0] BYTES_512 = 12'h200;
   localparam int FMT_W = 6;
   localparam logic [5:0] FMT_MPEG = 6'h20;
   localparam logic [5:0] FMT_DV = 6'h00;

   function automatic logic [11:0] level_bytes(input logic [1:0] lvl);
      unique case (lvl)
         LEVEL_2K: level_bytes = BYTES_2K;
         LEVEL_1K7: level_bytes = BYTES_1K7;
         LEVEL_1K: level_bytes = BYTES_1K;
         LEVEL_512: level_bytes = BYTES_512;
      endcase
   endfunction
endpackage

// *** hdl/lec_tx_start.sv ***
module lec_tx_start (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   input wire logic ce,
   // settings
   input wire logic [1:0] levelSel,
   input wire logic gate,
   input wire logic retriesZero,
   // fifo state
   input wire logic [lec_pkg::BYTES_W-1:0] fifoBytes,
   input wire logic eopInFifo,
   input wire logic fifoEmpty,
   input wire logic pktDone,
   // decisions
   output logic txStart,
   output logic underrun,
   output logic retryHold,
   output logic storeFwd
);
   typedef enum logic {TX_IDLE, TX_SEND} lec_tx_t;
   lec_tx_t state_r;
   logic sfNow;
   logic goNow;

   // gate low: no early start, plain store-and-forward
   assign sfNow = !gate || retriesZero || retryHold ||
                  (levelSel == lec_pkg::LEVEL_2K);
   assign goNow = sfNow ? eopInFifo :
                  (eopInFifo || fifoBytes >= lec_pkg::level_bytes(levelSel));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= TX_IDLE;
         txStart <= 1'b0;
         underrun <= 1'b0;
         retryHold <= 1'b0;
         storeFwd <= 1'b1;
      end else if (ce) begin
         txStart <= 1'b0;
         underrun <= 1'b0;
         storeFwd <= sfNow;
         unique case (state_r)
            TX_IDLE: begin
               if (goNow) begin
                  txStart <= 1'b1;
                  state_r <= TX_SEND;
               end
            end
            TX_SEND: begin
               if (fifoEmpty && !eopInFifo && !pktDone) begin
                  // drained before the tail arrived
                  underrun <= 1'b1;
                  retryHold <= 1'b1;
                  state_r <= TX_IDLE;
               end else if (pktDone) begin
                  retryHold <= 1'b0;
                  state_r <= TX_IDLE;
               end
            end
         endcase
      end
   end
endmodule // lec_tx_start

// *** hdl/lec_link_enh.sv ***
module lec_link_enh (
   // clock, enable and resets
   input wire logic clock,
   input wire logic ce,
   input wire logic rst_n,
   input wire logic global_reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lec_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial eeprom load
   input wire logic eepromLoad,
   input wire logic [15:0] eepromData,
   // host controller state
   input wire logic phy_enhance_gate,
   input wire logic retriesZero,
   // async transmit fifo
   input wire logic [lec_pkg::BYTES_W-1:0] fifoBytes,
   input wire logic eopInFifo,
   input wire logic fifoEmpty,
   input wire logic pktDone,
   output logic txStart,
   output logic txUnderrun,
   output logic storeFwd,
   // stream stamp qualifier
   input wire logic fmtValid,
   input wire logic [lec_pkg::FMT_W-1:0] streamFmt,
   output logic stampFixApply,
   // link controls
   output logic async_tx_overlap_disable,
   output logic priorityReqEn,
   output logic accelSupport
);
   logic [15:0] globalBits_r;
   logic [1:0] level_r;
   logic [31:0] regValue;
   logic [31:0] statusValue;
   logic [15:0] wrData;
   logic [15:0] wrMask;
   logic setupHit;
   logic writeFire;
   logic hitCtrl;
   logic hitStatus;
   logic retryHold;

   assign hitCtrl = paddr == lec_pkg::LINK_ENH_OFFSET;
   assign hitStatus = paddr == lec_pkg::STATUS_OFFSET;
   assign setupHit = psel && !penable;
   assign writeFire = psel && penable && pready && pwrite && hitCtrl;
   assign wrData = pwdata[15:0];
   // reserved positions never take a write
   assign wrMask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & lec_pkg::LINK_ENH_WMASK;

   // upper half and reserved bits stay zero
   assign regValue = {16'h0000, (globalBits_r & lec_pkg::GLOBAL_MASK) |
                      {2'h0, level_r, 12'h000}};
   assign statusValue = {27'h0, phy_enhance_gate, level_r, storeFwd, retryHold};

   // software write wins over an eeprom load in the same cycle
   always_ff @(posedge clock or negedge global_reset_n) begin
      if (!global_reset_n) begin
         globalBits_r <= lec_pkg::LINK_ENH_RESET[15:0] & lec_pkg::GLOBAL_MASK;
      end else if (ce) begin
         if (writeFire) begin
            globalBits_r <= (globalBits_r & ~wrMask) | (wrData & wrMask);
         end else if (eepromLoad) begin
            globalBits_r <= eepromData & lec_pkg::GLOBAL_MASK;
         end
      end
   end

   // start level follows the ordinary reset, unlike the bits above
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         level_r <= lec_pkg::LINK_ENH_RESET[lec_pkg::BIT_LEVEL_LO +: 2];
      end else if (ce) begin
         if (writeFire && pstrb[1]) begin
            level_r <= wrData[lec_pkg::BIT_LEVEL_LO +: 2];
         end else if (eepromLoad) begin
            level_r <= eepromData[lec_pkg::BIT_LEVEL_LO +: 2];
         end
      end
   end

   // no wait state: data set up in the setup cycle, ready in the first access cycle
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (ce) begin
         pready <= setupHit;
         if (setupHit) begin
            pslverr <= !(hitCtrl || hitStatus) || (pwrite && hitStatus);
            if (pwrite || !(hitCtrl || hitStatus)) begin
               prdata <= 32'h00000000;
            end else if (hitCtrl) begin
               prdata <= regValue;
            end else begin
               prdata <= statusValue;
            end
         end
      end
   end

   // gated link controls
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         async_tx_overlap_disable <= 1'b0;
         priorityReqEn <= 1'b0;
         accelSupport <= 1'b0;
         stampFixApply <= 1'b0;
      end else if (ce) begin
         async_tx_overlap_disable <= phy_enhance_gate &&
                                     globalBits_r[lec_pkg::BIT_OVERLAP_DIS];
         priorityReqEn <= phy_enhance_gate && globalBits_r[lec_pkg::BIT_PRIO_REQ];
         accelSupport <= phy_enhance_gate && globalBits_r[lec_pkg::BIT_ACCEL];
         stampFixApply <= fmtValid && phy_enhance_gate &&
            ((globalBits_r[lec_pkg::BIT_MPEG_FIX] && streamFmt == lec_pkg::FMT_MPEG) ||
             (globalBits_r[lec_pkg::BIT_DV_FIX] && streamFmt == lec_pkg::FMT_DV));
      end
   end

   lec_tx_start u_start (
      .clock(clock),
      .rst_n(rst_n),
      .ce(ce),
      .levelSel(level_r),
      .gate(phy_enhance_gate),
      .retriesZero(retriesZero),
      .fifoBytes(fifoBytes),
      .eopInFifo(eopInFifo),
      .fifoEmpty(fifoEmpty),
      .pktDone(pktDone),
      .txStart(txStart),
      .underrun(txUnderrun),
      .retryHold(retryHold),
      .storeFwd(storeFwd)
   );
endmodule // lec_link_enh

// *** tb/lec_link_enh_assertions.sv ***
module lec_link_enh_chk (
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic [lec_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // controls and transmit
   input wire logic phy_enhance_gate,
   input wire logic retriesZero,
   input wire logic eopInFifo,
   input wire logic txStart,
   input wire logic txUnderrun,
   input wire logic storeFwd,
   input wire logic async_tx_overlap_disable,
   input wire logic priorityReqEn,
   input wire logic accelSupport
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   upper_zero_a: assert property (
      pready |-> prdata[31:16] == 16'h0000) else $error("upper half not zero");
   rsvd_zero_a: assert property (
      pready && paddr == 12'h0f4 |-> (prdata[15:0] & ~lec_pkg::LINK_ENH_WMASK) == 16'h0000)
      else $error("reserved bit set");
   gate_off_a: assert property (
      !$past(phy_enhance_gate) |-> !(async_tx_overlap_disable | priorityReqEn | accelSupport))
      else $error("control active with gate low");
   ready_next_a: assert property (
      psel && !penable |=> pready) else $error("no ready in access cycle");
   bad_addr_a: assert property (
      pready && paddr != 12'h0f4 && paddr != 12'h0f0 |-> pslverr && prdata == 32'h0)
      else $error("unmapped access not refused");
   start_pulse_a: assert property (
      txStart |=> !txStart) else $error("start longer than one cycle");
   sfwd_wait_a: assert property (
      $past(retriesZero) && !$past(eopInFifo) |-> !txStart) else $error("early start");
   underrun_sf_a: assert property (
      txUnderrun |=> storeFwd) else $error("no store-and-forward after underrun");
endmodule // lec_link_enh_chk

bind lec_link_enh lec_link_enh_chk u_chk (.clock(clock), .rst_n(rst_n), .psel(psel),
   .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .phy_enhance_gate(phy_enhance_gate), .retriesZero(retriesZero), .eopInFifo(eopInFifo),
   .txStart(txStart), .txUnderrun(txUnderrun), .storeFwd(storeFwd),
   .async_tx_overlap_disable(async_tx_overlap_disable), .priorityReqEn(priorityReqEn),
   .accelSupport(accelSupport));

// *** tb/lec_link_enh_tb.sv ***
module lec_link_enh_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 0, rst_n = 0, gRstN = 0, psel = 0, penable = 0, pwrite = 0, eeLd = 0;
   logic gate = 0, retZ = 0, eop = 0, fEmpty = 0, pktDone = 0, fmtValid = 0;
   logic ce = 1'b1;
   logic err;
   logic txStart, txUnderrun, storeFwd, stampFix, ovlDis, prio, accel, pready, pslverr, sS, sU;
   logic [11:0] paddr = 0, fBytes = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] eeData = 0;
   logic [5:0] fmt = 0;
   int fails = 0, checks_done = 0;
   always #5 clock = ~clock;
   lec_link_enh DUT (.clock(clock), .ce(ce), .rst_n(rst_n), .global_reset_n(gRstN),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr), .eepromLoad(eeLd),
      .eepromData(eeData), .phy_enhance_gate(gate), .retriesZero(retZ), .fifoBytes(fBytes),
      .eopInFifo(eop), .fifoEmpty(fEmpty), .pktDone(pktDone), .txStart(txStart),
      .txUnderrun(txUnderrun), .storeFwd(storeFwd), .fmtValid(fmtValid), .streamFmt(fmt),
      .stampFixApply(stampFix), .async_tx_overlap_disable(ovlDis), .priorityReqEn(prio),
      .accelSupport(accel));
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock) penable <= 1;
      do @(posedge clock); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      // idle edge so a following call never reassigns psel in the same step
      @(posedge clock);
   endtask
   task run;
      sS = 0; sU = 0;
      repeat (3) begin
         @(posedge clock);
         sS |= txStart;
         sU |= txUnderrun;
      end
   endtask
   task t_regs;
      apb(0, 12'h0f4, 0); chk("reset value", rd, 32'h1000);
      // bit 14 stays zero in every write, as software must keep it
      apb(1, 12'h0f4, 32'hffffbfff); apb(0, 12'h0f4, 0); chk("masked", rd, 32'hb582);
      gate <= 1; run; chk("controls on", {ovlDis, prio, accel}, 3'b111);
      gate <= 0; run; chk("controls gated", {ovlDis, prio, accel}, 3'b000);
      apb(0, 12'h0f8, 0);
      chk("unmapped err", err, 1'b1);
      chk("unmapped data", rd, 32'h00000000);
      rst_n <= 0; @(posedge clock) rst_n <= 1;
      apb(0, 12'h0f4, 0); chk("global bits kept", rd, 32'h9582);
      gRstN <= 0; @(posedge clock) gRstN <= 1;
      apb(0, 12'h0f4, 0); chk("global clear", rd, 32'h1000);
      eeData <= 16'hbfff; eeLd <= 1; @(posedge clock) eeLd <= 0;
      apb(0, 12'h0f4, 0); chk("eeprom load", rd, 32'hb582);
      // a load while the clock enable is low must not land
      ce <= 1'b0; eeData <= 16'h0000; eeLd <= 1'b1; @(posedge clock) eeLd <= 1'b0;
      ce <= 1'b1;
      apb(0, 12'h0f4, 0); chk("frozen load", rd, 32'hb582);
   endtask
   task t_stamp;
      apb(1, 12'h0f4, 32'h0500); gate <= 1; fmtValid <= 1; fmt <= 6'h20;
      repeat (2) @(posedge clock);
      chk("mpeg stamp", stampFix, 1);
      fmt <= 6'h01; repeat (2) @(posedge clock); chk("other fmt", stampFix, 0);
      fmt <= 6'h00; repeat (2) @(posedge clock); chk("dv stamp", stampFix, 1);
      gate <= 1'b0; repeat (2) @(posedge clock); chk("stamp gated", stampFix, 0);
      gate <= 1'b1;
   endtask
   task t_tx;
      apb(1, 12'h0f4, 32'h3000); fBytes <= 12'h1ff; run; chk("below 512", sS, 0);
      fBytes <= 12'h200; run; chk("at 512", sS, 1);
      fEmpty <= 1; run; chk("underrun", sU, 1);
      fEmpty <= 0; fBytes <= 12'hfff; run; chk("retry waits", sS, 0);
      chk("retry store fwd", storeFwd, 1'b1);
      eop <= 1; run; chk("retry whole", sS, 1);
      pktDone <= 1; eop <= 0; @(posedge clock) pktDone <= 0;
      retZ <= 1; run; chk("retries zero", sS, 0);
      retZ <= 0; run; chk("threshold again", sS, 1);
      chk("cut through", storeFwd, 1'b0);
   endtask
   task t_levels;
      // each step first closes the open packet so the sequencer is idle
      pktDone <= 1'b1; fBytes <= 12'h000; @(posedge clock) pktDone <= 1'b0;
      apb(1'b1, 12'h0f4, 32'h00001000); fBytes <= 12'h6cc; run;
      chk("below 1k7", sS, 1'b0);
      fBytes <= 12'h6cd; run; chk("at 1k7", sS, 1'b1);
      pktDone <= 1'b1; fBytes <= 12'h000; @(posedge clock) pktDone <= 1'b0;
      apb(1'b1, 12'h0f4, 32'h00002000); fBytes <= 12'h3ff; run;
      chk("below 1k", sS, 1'b0);
      fBytes <= 12'h400; run; chk("at 1k", sS, 1'b1);
      pktDone <= 1'b1; fBytes <= 12'h000; @(posedge clock) pktDone <= 1'b0;
      apb(1'b1, 12'h0f4, 32'h00000000); fBytes <= 12'hfff; run;
      chk("2k waits", sS, 1'b0);
      eop <= 1'b1; run; chk("2k whole", sS, 1'b1);
      pktDone <= 1'b1; eop <= 1'b0; fBytes <= 12'h000; @(posedge clock) pktDone <= 1'b0;
      apb(1'b1, 12'h0f4, 32'h00003000); gate <= 1'b0; fBytes <= 12'hfff; run;
      chk("gate off start", sS, 1'b0);
      chk("gate off store fwd", storeFwd, 1'b1);
      gate <= 1'b1; run; chk("gate on start", sS, 1'b1);
   endtask
   task tally_and_finish;
      if (fails == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clock);
      rst_n <= 1; gRstN <= 1;
      @(posedge clock);
      t_regs;
      t_stamp;
      t_tx;
      t_levels;
      tally_and_finish;
   end
   initial begin
      #20000;
      fails++;
      tally_and_finish;
   end
endmodule // lec_link_enh_tb
